// ### src/tccu_pkg.sv
// Constants, register map and carrier types of the timer capture/compare unit
package tccu_pkg;

  localparam int NUM_MODULES = 4;

  // Register byte addresses
  localparam logic [7:0] ADDR_MODE_CTRL = 8'hC1;
  localparam logic [7:0] ADDR_MAIN_CTRL = 8'hC8;
  localparam logic [7:0] ADDR_PRESCALER_CTRL = 8'hC9;
  localparam logic [7:0] ADDR_COUNTER_LOW = 8'hCC;
  localparam logic [7:0] ADDR_COUNTER_HIGH = 8'hCD;
  localparam logic [7:0] ADDR_IRQ_FLAGS = 8'hCE;
  localparam logic [7:0] ADDR_IRQ_ENABLES = 8'hCF;
  localparam logic [7:0] ADDR_PORT_DATA = 8'hD0;
  localparam logic [7:0] ADDR_CLKOUT_CTRL = 8'hFE;
  // Capture pair per module, index 0 is the reload/capture pair
  localparam logic [3:0][7:0] ADDR_CAP_LOW = {8'hC6, 8'hC4, 8'hC2, 8'hCA};
  localparam logic [3:0][7:0] ADDR_CAP_HIGH = {8'hC7, 8'hC5, 8'hC3, 8'hCB};

  // Field positions
  localparam int MAIN_EDGE_SEL_BIT = 6;
  localparam int MAIN_RELOAD_LSB = 3;
  localparam int MAIN_CMP_MODE_BIT = 2;
  localparam int MAIN_CLKSRC_LSB = 0;
  localparam int CLKOUT_INIT_BIT = 3;
  localparam int CLKOUT_EN_BIT = 2;
  localparam int PRESCALE_LSB = 0;
  localparam int FLAG_OVF_BIT = 4;
  localparam int FLAG_EXT_BIT = 5;
  localparam int EN_TIMER_BIT = 4;
  localparam int EN_EXT_BIT = 5;

  // Implemented bits, the rest read as zero
  localparam logic [7:0] MAIN_CTRL_MASK = 8'h5F;

  // Values after reset
  localparam logic [7:0] MODE_CTRL_RESET = 8'h00;
  localparam logic [7:0] MAIN_CTRL_RESET = 8'h00;
  localparam logic [1:0] PRESCALE_RESET = 2'h0;
  localparam logic CLKOUT_INIT_RESET = 1'b1;
  localparam logic CLKOUT_EN_RESET = 1'b0;
  localparam logic [15:0] COUNTER_RESET = 16'h0000;
  localparam logic [15:0] CAP_RESET = 16'h0000;
  localparam logic [3:0] NIBBLE_RESET = 4'h0;

  // Reload mode field codes
  localparam logic [1:0] RELOAD_ON_OVERFLOW = 2'h2;
  localparam logic [1:0] RELOAD_ON_TRIGGER = 2'h3;

  localparam logic [15:0] COUNTER_MAX = 16'hFFFF;
  localparam logic [15:0] COUNTER_STEP = 16'h0001;

  // Prescaler divide ratios selected by the two prescale bits
  localparam logic [3:0][7:0] PRESCALE_DIV = {8'h08, 8'h04, 8'h02, 8'h01};
  localparam logic [7:0] PRESCALE_ONE = 8'h01;

  typedef enum logic [1:0] {
    MODE_OFF,
    MODE_EDGE_CAPTURE,
    MODE_COMPARE,
    MODE_WRITE_CAPTURE
  } tccu_mode_e;

  typedef enum logic [1:0] {
    CLKSRC_STOP,
    CLKSRC_INTERNAL,
    CLKSRC_EVENT,
    CLKSRC_GATED
  } tccu_clksrc_e;

  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
  } tccu_bus_s;

endpackage : tccu_pkg

// ### src/tccu_prescale.sv
// Prescaler giving a one-cycle count enable at the selected rate
`timescale 1ns/10ps
module tccu_prescale
  import tccu_pkg::*;
(
  input wire logic mclk_i,
  input wire logic reset_i,
  input wire logic [1:0] sel_i,
  output logic tick_o
);

  logic [7:0] count;
  logic [7:0] limit;

  assign limit = PRESCALE_DIV[sel_i] - PRESCALE_ONE;

  // A shrinking ratio is caught by the >= compare, no stall
  always_ff @(posedge mclk_i)
  begin
    if (reset_i)
    begin
      count <= 8'h00;
      tick_o <= 1'b0;
    end
    else if (count >= limit)
    begin
      count <= 8'h00;
      tick_o <= 1'b1;
    end
    else
    begin
      count <= count + PRESCALE_ONE;
      tick_o <= 1'b0;
    end
  end

endmodule : tccu_prescale

// ### src/tccu_sync.sv
// Three-stage pin synchroniser with agreement filter and edge pulses
`timescale 1ns/10ps
module tccu_sync
  import tccu_pkg::*;
#(
  parameter int WIDTH = 6
)
(
  input wire logic mclk_i,
  input wire logic reset_i,
  input wire logic [WIDTH-1:0] pin_i,
  output logic [WIDTH-1:0] level_o,
  output logic [WIDTH-1:0] rise_o,
  output logic [WIDTH-1:0] fall_o
);

  logic [WIDTH-1:0] stage1;
  logic [WIDTH-1:0] stage2;
  logic [WIDTH-1:0] stage3;
  logic [WIDTH-1:0] level_q;

  always_ff @(posedge mclk_i)
  begin
    if (reset_i)
    begin
      stage1 <= '0;
      stage2 <= '0;
      stage3 <= '0;
    end
    else
    begin
      stage1 <= pin_i;
      stage2 <= stage1;
      stage3 <= stage2;
    end
  end

  // Level follows only where the last two stages agree
  always_ff @(posedge mclk_i)
  begin
    if (reset_i)
    begin
      level_o <= '0;
      level_q <= '0;
    end
    else
    begin
      level_o <= (stage2 & stage3) | (level_o & (stage2 | stage3));
      level_q <= level_o;
    end
  end

  assign rise_o = level_o & ~level_q;
  assign fall_o = ~level_o & level_q;

endmodule : tccu_sync

// ### src/tccu_top.sv
// Timer counter with four capture/compare modules, reload and clock output
//
// The plain strobed port and the placing of the registers were left to the implementer.
`timescale 1ns/10ps
//
// Contract
// RULE_01 - Clock-output pin driven only while clock-output enable is set.
// RULE_02 - Clock-output pin idles at the software-chosen initial level.
// RULE_03 - Modules 1-3 in mode 01 capture the counter on rising pin edge.
// RULE_04 - Module 0 edge capture on rising or falling edge per edge select.
// RULE_05 - Edge capture with module interrupt enabled sets module flag.
// RULE_06 - Mode 11: write to low capture byte triggers capture next cycle.
// RULE_07 - Write-triggered capture never sets the module flag.
// RULE_08 - Compare mode sets module flag when counter equals its pair.
// RULE_09 - Compare mode select 0: output high on match, low on overflow.
// RULE_10 - Compare mode select 1: shadow bit copied on match; overflow ignored.
// RULE_11 - Port data bit acts as compare shadow bit while pin is compare output.
// RULE_12 - Reload mode 0: overflow loads module 0 pair and raises timer irq.
// RULE_13 - Reload mode 1: falling reload-trigger edge loads module 0 pair.
// RULE_14 - External reload interrupt needs both its enable and timer enable.
// RULE_15 - Clock-output mode reloads on overflow and toggles the pin.
// RULE_16 - Output frequency is tick rate over twice (65536 minus reload).
// RULE_17 - Software selects internal clock and sets enable for clock output.
// RULE_18 - Mode field: 00 off, 01 edge capture, 10 compare, 11 write capture.
// RULE_19 - Any counter overflow sets the timer overflow flag.
// RULE_20 - Capture stores both counter bytes in the same cycle.
module tccu_top
  import tccu_pkg::*;
(
  input wire logic mclk_i,
  input wire logic reset_i,
  input tccu_bus_s bus_i,
  output logic [7:0] rdata_o,
  input wire logic [3:0] module_pin_i,
  output logic [3:0] module_pin_o,
  output logic [3:0] module_pin_oe_o,
  input wire logic reload_trigger_pin_i,
  input wire logic timer_ext_pin_i,
  output logic timer_ext_pin_o,
  output logic timer_ext_pin_oe_o,
  output logic [3:0] module_irq_o,
  output logic timer_irq_o
);

  function automatic tccu_mode_e module_mode(input logic [7:0] ctrl, input int idx);
    return tccu_mode_e'(ctrl[idx*2 +: 2]);
  endfunction : module_mode

  function automatic logic wr_hit(input tccu_bus_s bus, input logic [7:0] addr);
    return bus.wr && (bus.addr == addr);
  endfunction : wr_hit

  // Software state
  logic [7:0] module_mode_ctrl;
  logic [7:0] timer_main_ctrl;
  logic [1:0] prescaler_ctrl;
  logic clkout_enable;
  logic clkout_initial_level;
  logic [3:0] module_irq_enable;
  logic timer_irq_enable;
  logic ext_reload_irq_enable;
  logic [3:0] port_data_bit;

  // Hardware state
  logic [15:0] counter;
  logic [15:0] cap [NUM_MODULES];
  logic [3:0] module_irq_flag;
  logic timer_overflow_flag;
  logic ext_reload_flag;
  logic [3:0] write_capture_pending;
  logic count_moved;
  logic clkout_level;

  // Decoded controls
  tccu_clksrc_e clock_source;
  logic [1:0] reload_mode;
  logic compare_mode_select;
  logic module0_edge_select;

  assign clock_source = tccu_clksrc_e'(timer_main_ctrl[MAIN_CLKSRC_LSB +: 2]);
  assign reload_mode = timer_main_ctrl[MAIN_RELOAD_LSB +: 2];
  assign compare_mode_select = timer_main_ctrl[MAIN_CMP_MODE_BIT];
  assign module0_edge_select = timer_main_ctrl[MAIN_EDGE_SEL_BIT];

  // Pin conditioning
  logic [5:0] pin_level;
  logic [5:0] pin_rise;
  logic [5:0] pin_fall;
  logic prescale_tick;

  tccu_sync #(
    .WIDTH(6)
  ) u_sync (
    .mclk_i(mclk_i),
    .reset_i(reset_i),
    .pin_i({timer_ext_pin_i, reload_trigger_pin_i, module_pin_i}),
    .level_o(pin_level),
    .rise_o(pin_rise),
    .fall_o(pin_fall)
  );

  tccu_prescale u_prescale (
    .mclk_i(mclk_i),
    .reset_i(reset_i),
    .sel_i(prescaler_ctrl),
    .tick_o(prescale_tick)
  );

  // Counting and overflow
  logic count_en;
  logic overflow;
  logic ext_reload;
  logic auto_reload;

  always_comb
  begin
    unique case (clock_source)
      CLKSRC_STOP: count_en = 1'b0;
      CLKSRC_INTERNAL: count_en = prescale_tick;
      CLKSRC_EVENT: count_en = pin_fall[5];
      CLKSRC_GATED: count_en = prescale_tick & pin_level[5];
    endcase
  end

  assign overflow = count_en && (counter == COUNTER_MAX);
  assign ext_reload = (reload_mode == RELOAD_ON_TRIGGER) && pin_fall[4]; // RULE_13
  // Clock output reuses the overflow reload, halving at 65536 minus reload
  assign auto_reload = overflow &&
                       ((reload_mode == RELOAD_ON_OVERFLOW) || clkout_enable); // RULE_12 RULE_15 RULE_16

  always_ff @(posedge mclk_i)
  begin
    if (reset_i)
    begin
      counter <= COUNTER_RESET;
      count_moved <= 1'b0;
    end
    else
    begin
      count_moved <= count_en | ext_reload;
      if (wr_hit(bus_i, ADDR_COUNTER_LOW))
        counter[7:0] <= bus_i.wdata;
      else if (wr_hit(bus_i, ADDR_COUNTER_HIGH))
        counter[15:8] <= bus_i.wdata;
      else if (ext_reload || auto_reload)
        counter <= cap[0]; // RULE_12 RULE_13 RULE_15
      else if (count_en)
        counter <= counter + COUNTER_STEP;
    end
  end

  // Capture and compare events per module
  logic [3:0] edge_capture;
  logic [3:0] capture;
  logic [3:0] match;
  logic [3:0] low_write;
  logic [3:0] high_write;
  logic [3:0] is_compare;

  always_comb
  begin
    for (int i = 0; i < NUM_MODULES; i++)
    begin
      low_write[i] = wr_hit(bus_i, ADDR_CAP_LOW[i]);
      high_write[i] = wr_hit(bus_i, ADDR_CAP_HIGH[i]);
      is_compare[i] = module_mode(module_mode_ctrl, i) == MODE_COMPARE; // RULE_18
      edge_capture[i] = 1'b0;
      if (module_mode(module_mode_ctrl, i) == MODE_EDGE_CAPTURE) // RULE_18
      begin
        if (i == 0)
          edge_capture[i] = module0_edge_select ? pin_rise[0] : pin_fall[0]; // RULE_04
        else
          edge_capture[i] = pin_rise[i]; // RULE_03
      end
      capture[i] = edge_capture[i] | write_capture_pending[i];
      match[i] = is_compare[i] && count_moved && (counter == cap[i]);
    end
  end

  // Write-capture waits one cycle so the written value never lands
  always_ff @(posedge mclk_i)
  begin
    if (reset_i)
      write_capture_pending <= NIBBLE_RESET;
    else
    begin
      for (int i = 0; i < NUM_MODULES; i++)
        write_capture_pending[i] <= low_write[i] &&
          (module_mode(module_mode_ctrl, i) == MODE_WRITE_CAPTURE); // RULE_06
    end
  end

  always_ff @(posedge mclk_i)
  begin
    if (reset_i)
    begin
      for (int i = 0; i < NUM_MODULES; i++)
        cap[i] <= CAP_RESET;
    end
    else
    begin
      for (int i = 0; i < NUM_MODULES; i++)
      begin
        if (capture[i])
          cap[i] <= counter; // RULE_20
        else if (low_write[i] &&
                 (module_mode(module_mode_ctrl, i) != MODE_WRITE_CAPTURE))
          cap[i][7:0] <= bus_i.wdata;
        else if (high_write[i])
          cap[i][15:8] <= bus_i.wdata;
      end
    end
  end

  // Flags: a set in the cycle of its clear wins
  logic [3:0] next_module_irq_flag;
  logic flag_write;

  assign flag_write = wr_hit(bus_i, ADDR_IRQ_FLAGS);

  always_comb
  begin
    for (int i = 0; i < NUM_MODULES; i++)
      next_module_irq_flag[i] = (edge_capture[i] & module_irq_enable[i]) | // RULE_05 RULE_07
                                match[i] | // RULE_08
                                (module_irq_flag[i] & ~(flag_write & bus_i.wdata[i]));
  end

  always_ff @(posedge mclk_i)
  begin
    if (reset_i)
    begin
      module_irq_flag <= NIBBLE_RESET;
      timer_overflow_flag <= 1'b0;
      ext_reload_flag <= 1'b0;
    end
    else
    begin
      module_irq_flag <= next_module_irq_flag;
      timer_overflow_flag <= overflow | // RULE_19 RULE_12
        (timer_overflow_flag & ~(flag_write & bus_i.wdata[FLAG_OVF_BIT]));
      ext_reload_flag <= (ext_reload & ext_reload_irq_enable) | // RULE_14
        (ext_reload_flag & ~(flag_write & bus_i.wdata[FLAG_EXT_BIT]));
    end
  end

  always_ff @(posedge mclk_i)
  begin
    if (reset_i)
    begin
      module_irq_o <= NIBBLE_RESET;
      timer_irq_o <= 1'b0;
    end
    else
    begin
      module_irq_o <= module_irq_flag & module_irq_enable;
      timer_irq_o <= timer_irq_enable & (timer_overflow_flag | ext_reload_flag); // RULE_14
    end
  end

  // Compare outputs on the module pins
  always_ff @(posedge mclk_i)
  begin
    if (reset_i)
    begin
      module_pin_o <= NIBBLE_RESET;
      module_pin_oe_o <= NIBBLE_RESET;
    end
    else
    begin
      module_pin_oe_o <= is_compare; // RULE_11
      for (int i = 0; i < NUM_MODULES; i++)
      begin
        if (match[i])
          module_pin_o[i] <= compare_mode_select ? port_data_bit[i] : 1'b1; // RULE_09 RULE_10 RULE_11
        else if (overflow && !compare_mode_select)
          module_pin_o[i] <= 1'b0; // RULE_09
      end
    end
  end

  // Clock output on the shared timer pin
  always_ff @(posedge mclk_i)
  begin
    if (reset_i)
    begin
      clkout_level <= CLKOUT_INIT_RESET;
      timer_ext_pin_oe_o <= 1'b0;
    end
    else
    begin
      timer_ext_pin_oe_o <= clkout_enable; // RULE_01
      if (!clkout_enable)
        clkout_level <= clkout_initial_level; // RULE_02
      else if (overflow)
        clkout_level <= ~clkout_level; // RULE_15
    end
  end

  assign timer_ext_pin_o = clkout_level;

  // Control registers; clock source comes from software alone
  always_ff @(posedge mclk_i)
  begin
    if (reset_i)
    begin
      module_mode_ctrl <= MODE_CTRL_RESET;
      timer_main_ctrl <= MAIN_CTRL_RESET;
      prescaler_ctrl <= PRESCALE_RESET;
      clkout_enable <= CLKOUT_EN_RESET;
      clkout_initial_level <= CLKOUT_INIT_RESET;
      module_irq_enable <= NIBBLE_RESET;
      timer_irq_enable <= 1'b0;
      ext_reload_irq_enable <= 1'b0;
      port_data_bit <= NIBBLE_RESET;
    end
    else if (bus_i.wr)
    begin
      unique case (bus_i.addr)
        ADDR_MODE_CTRL: module_mode_ctrl <= bus_i.wdata;
        ADDR_MAIN_CTRL: timer_main_ctrl <= bus_i.wdata & MAIN_CTRL_MASK; // RULE_17
        ADDR_PRESCALER_CTRL: prescaler_ctrl <= bus_i.wdata[PRESCALE_LSB +: 2];
        ADDR_CLKOUT_CTRL:
        begin
          clkout_enable <= bus_i.wdata[CLKOUT_EN_BIT];
          clkout_initial_level <= bus_i.wdata[CLKOUT_INIT_BIT];
        end
        ADDR_IRQ_ENABLES:
        begin
          module_irq_enable <= bus_i.wdata[3:0];
          timer_irq_enable <= bus_i.wdata[EN_TIMER_BIT];
          ext_reload_irq_enable <= bus_i.wdata[EN_EXT_BIT];
        end
        ADDR_PORT_DATA: port_data_bit <= bus_i.wdata[3:0];
        default: ;
      endcase
    end
  end

  // Read path, data valid only in the cycle after the strobe
  logic [7:0] read_value;

  always_comb
  begin
    read_value = 8'h00;
    unique case (bus_i.addr)
      ADDR_MODE_CTRL: read_value = module_mode_ctrl;
      ADDR_MAIN_CTRL: read_value = timer_main_ctrl;
      ADDR_PRESCALER_CTRL: read_value = {6'h00, prescaler_ctrl};
      ADDR_CLKOUT_CTRL: read_value = {4'h0, clkout_initial_level, clkout_enable, 2'h0};
      ADDR_COUNTER_LOW: read_value = counter[7:0];
      ADDR_COUNTER_HIGH: read_value = counter[15:8];
      ADDR_IRQ_FLAGS:
        read_value = {2'h0, ext_reload_flag, timer_overflow_flag, module_irq_flag};
      ADDR_IRQ_ENABLES:
        read_value = {2'h0, ext_reload_irq_enable, timer_irq_enable, module_irq_enable};
      ADDR_PORT_DATA: read_value = {4'h0, port_data_bit};
      default:
      begin
        for (int i = 0; i < NUM_MODULES; i++)
        begin
          if (bus_i.addr == ADDR_CAP_LOW[i])
            read_value = cap[i][7:0];
          if (bus_i.addr == ADDR_CAP_HIGH[i])
            read_value = cap[i][15:8];
        end
      end
    endcase
  end

  always_ff @(posedge mclk_i)
  begin
    if (reset_i)
      rdata_o <= 8'h00;
    else if (bus_i.rd)
      rdata_o <= read_value;
    else
      rdata_o <= 8'h00;
  end

endmodule : tccu_top

// ### verif/tccu_pins.sv
// Far-side pin model: capture, reload-trigger and timer pins
`timescale 1ns/10ps
module tccu_pins
  import tccu_pkg::*;
#(
  parameter int LAG = 1
)
(
  input wire logic mclk_i,
  input wire logic [3:0] cap_lvl_i,
  input wire logic trig_lvl_i,
  input wire logic ext_lvl_i,
  input wire logic [3:0] cmp_out_i,
  input wire logic [3:0] cmp_oe_i,
  input wire logic clk_out_i,
  input wire logic clk_oe_i,
  output logic [3:0] cap_pin_o,
  output logic trig_pin_o,
  output logic ext_pin_o
);
  // Lag stands for slow external drivers; pins start low, trigger idles high
  logic [LAG:0][5:0] pipe = {(LAG + 1){6'h10}};
  always @(posedge mclk_i)
  begin
    pipe <= {pipe[LAG-1:0], {ext_lvl_i, trig_lvl_i, cap_lvl_i}};
  end
  // Shared pins carry the device level whenever the device drives them
  assign cap_pin_o = (cmp_oe_i & cmp_out_i) | (~cmp_oe_i & pipe[LAG][3:0]);
  assign trig_pin_o = pipe[LAG][4];
  assign ext_pin_o = clk_oe_i ? clk_out_i : pipe[LAG][5];
endmodule : tccu_pins

// ### verif/tccu_sva.sv
// Port-level assertions for the timer capture/compare unit
`timescale 1ns/10ps
module tccu_sva
  import tccu_pkg::*;
(
  input wire logic mclk_i,
  input wire logic reset_i,
  input tccu_bus_s bus_i,
  input wire logic [7:0] rdata_o,
  input wire logic [3:0] module_pin_o,
  input wire logic [3:0] module_pin_oe_o,
  input wire logic timer_ext_pin_o,
  input wire logic timer_ext_pin_oe_o,
  input wire logic [3:0] module_irq_o,
  input wire logic timer_irq_o
);
  default clocking cb @(posedge mclk_i);
  endclocking
  default disable iff (reset_i);
  logic [7:0] mode_sh;
  logic [5:0] en_sh;
  logic init_sh;
  logic clk_en_sh;
  logic [3:0] cmp_sh;
  // Shadows of writable controls, so outputs can be tied to their cause
  always_ff @(posedge mclk_i)
  begin
    if (reset_i)
    begin
      mode_sh <= MODE_CTRL_RESET;
      en_sh <= 6'h00;
      init_sh <= CLKOUT_INIT_RESET;
      clk_en_sh <= CLKOUT_EN_RESET;
    end
    else if (bus_i.wr)
    begin
      if (bus_i.addr == ADDR_MODE_CTRL)
      begin
        mode_sh <= bus_i.wdata;
      end
      if (bus_i.addr == ADDR_IRQ_ENABLES)
      begin
        en_sh <= bus_i.wdata[5:0];
      end
      if (bus_i.addr == ADDR_CLKOUT_CTRL)
      begin
        init_sh <= bus_i.wdata[CLKOUT_INIT_BIT];
        clk_en_sh <= bus_i.wdata[CLKOUT_EN_BIT];
      end
    end
  end
  always_comb
  begin
    for (int i = 0; i < NUM_MODULES; i++)
    begin
      cmp_sh[i] = mode_sh[2*i +: 2] == MODE_COMPARE;
    end
  end
  sequence mode_rd_s;
    bus_i.rd && bus_i.addr == ADDR_MODE_CTRL;
  endsequence
  oe_compare_a: assert property (module_pin_oe_o == $past(cmp_sh))
    else $error("pin enables do not follow compare mode");
  // Accepts one cycle of lag after a change of the enable bit
  clkout_oe_a: assert property ($stable(clk_en_sh) |-> timer_ext_pin_oe_o == clk_en_sh)
    else $error("clock pin enable differs from its control bit");
  idle_level_a: assert property (!clk_en_sh && $past(!clk_en_sh) && $stable(init_sh)
    |-> timer_ext_pin_o == init_sh)
    else $error("idle clock pin not at initial level");
  rdata_idle_a: assert property (!bus_i.rd |=> rdata_o == 8'h00)
    else $error("read data outside read answer");
  mode_read_a: assert property (mode_rd_s |=> rdata_o == $past(mode_sh))
    else $error("mode register read back wrong");
  module_irq_gate_a: assert property ((module_irq_o & ~$past(en_sh[3:0])) == 4'h0)
    else $error("module interrupt without its enable");
  timer_irq_gate_a: assert property (timer_irq_o |-> $past(en_sh[EN_TIMER_BIT]))
    else $error("timer interrupt without timer enable");
  for (genvar g = 0; g < NUM_MODULES; g++)
  begin : g_wcap
    write_cap_quiet_a: assert property (mode_sh[2*g +: 2] == MODE_WRITE_CAPTURE
      && $past(mode_sh[2*g +: 2], 8) == MODE_WRITE_CAPTURE && $past(en_sh, 2) == en_sh
      |-> !$rose(module_irq_o[g]))
      else $error("module flag raised during write capture");
  end
endmodule : tccu_sva

bind tccu_top tccu_sva i_sva (.mclk_i(mclk_i), .reset_i(reset_i), .bus_i(bus_i),
  .rdata_o(rdata_o), .module_pin_o(module_pin_o), .module_pin_oe_o(module_pin_oe_o),
  .timer_ext_pin_o(timer_ext_pin_o), .timer_ext_pin_oe_o(timer_ext_pin_oe_o),
  .module_irq_o(module_irq_o), .timer_irq_o(timer_irq_o));

// ### verif/tccu_top_tb.sv
// Self-checking bench for the timer capture/compare unit
`timescale 1ns/10ps
`define CHK(got, exp) begin n_tests++; if ((got) !== (exp)) begin fail_count++; \
  $display("wrong value at %0t: got %h expected %h", $time, got, exp); end end
module tccu_top_tb
  import tccu_pkg::*;
;
  logic mclk_i = 1'b0;
  logic reset_i = 1'b1;
  tccu_bus_s bus_i = '0;
  logic [7:0] rdata_o;
  logic [3:0] module_pin_i, module_pin_o, module_pin_oe_o, module_irq_o;
  logic reload_trigger_pin_i, timer_ext_pin_i, timer_ext_pin_o, timer_ext_pin_oe_o;
  logic timer_irq_o;
  logic [3:0] cap_lvl = 4'h0;
  logic trig_lvl = 1'b1;
  logic ext_lvl = 1'b0;
  logic [7:0] rv;
  int fail_count = 0;
  int n_tests = 0;
  int cnt;
  tccu_pins #(.LAG(2)) i_pins (.mclk_i(mclk_i), .cap_lvl_i(cap_lvl), .trig_lvl_i(trig_lvl),
    .ext_lvl_i(ext_lvl), .cmp_out_i(module_pin_o), .cmp_oe_i(module_pin_oe_o),
    .clk_out_i(timer_ext_pin_o), .clk_oe_i(timer_ext_pin_oe_o), .cap_pin_o(module_pin_i),
    .trig_pin_o(reload_trigger_pin_i), .ext_pin_o(timer_ext_pin_i));
  tccu_top i_dut (.mclk_i(mclk_i), .reset_i(reset_i), .bus_i(bus_i), .rdata_o(rdata_o),
    .module_pin_i(module_pin_i), .module_pin_o(module_pin_o),
    .module_pin_oe_o(module_pin_oe_o), .reload_trigger_pin_i(reload_trigger_pin_i),
    .timer_ext_pin_i(timer_ext_pin_i), .timer_ext_pin_o(timer_ext_pin_o),
    .timer_ext_pin_oe_o(timer_ext_pin_oe_o), .module_irq_o(module_irq_o),
    .timer_irq_o(timer_irq_o));
  initial
  begin
    forever #2.5 mclk_i = ~mclk_i;
  end
  task automatic results();
    $display("comparisons %0d, mismatches %0d", n_tests, fail_count);
    if (fail_count == 0 && n_tests > 0)
    begin
      $display("ALL CHECKS OK");
    end
    else
    begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : results
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge mclk_i);
    bus_i <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge mclk_i);
    bus_i.wr <= 1'b0;
    #1;
  endtask : wr
  // Read data stand only in the cycle after the strobe
  task automatic rchk(input logic [7:0] a, input logic [7:0] m, input logic [7:0] e);
    @(posedge mclk_i);
    bus_i <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
    @(posedge mclk_i);
    bus_i.rd <= 1'b0;
    #1;
    rv = rdata_o & m;
    `CHK(rv, e)
  endtask : rchk
  // Index 0-3 compare pins, 4 clock pin, 5 timer interrupt
  task automatic wait_for(input int idx, input logic lvl, output int c);
    logic [5:0] s;
    c = 0;
    do
    begin
      @(posedge mclk_i);
      #1;
      c++;
      s = {timer_irq_o, timer_ext_pin_o, module_pin_o};
    end
    while (s[idx] !== lvl && c < 300);
    if (c >= 300)
    begin
      fail_count++;
      $display("wrong value at %0t: wait on signal %0d timed out", $time, idx);
      results();
    end
  endtask : wait_for
  task automatic pins(input logic [3:0] v);
    @(posedge mclk_i);
    cap_lvl <= v;
    repeat (10) @(posedge mclk_i);
  endtask : pins
  initial
  begin
    repeat (50000) @(posedge mclk_i);
    fail_count++;
    $display("wrong value at %0t: run did not finish", $time);
    results();
  end
  initial
  begin
    repeat (20) @(posedge mclk_i);
    reset_i <= 1'b0;
    rchk(ADDR_MODE_CTRL, 8'hFF, MODE_CTRL_RESET);
    rchk(ADDR_MAIN_CTRL, 8'hFF, MAIN_CTRL_RESET);
    rchk(ADDR_CLKOUT_CTRL, 8'hFF, 8'h08);
    `CHK(timer_ext_pin_o, 1'b1)
    `CHK(timer_ext_pin_oe_o, 1'b0)
    wr(8'h00, 8'hFF);
    rchk(8'h00, 8'hFF, 8'h00);
    // Write capture on every module, stopped counter, written value ignored
    wr(ADDR_MODE_CTRL, 8'hFF);
    wr(ADDR_IRQ_ENABLES, 8'h0F);
    for (int i = 0; i < NUM_MODULES; i++)
    begin
      wr(ADDR_COUNTER_LOW, 8'(8'h30 + i));
      wr(ADDR_COUNTER_HIGH, 8'h12);
      wr(ADDR_CAP_LOW[i], 8'hA5);
      rchk(ADDR_CAP_LOW[i], 8'hFF, 8'(8'h30 + i));
      rchk(ADDR_CAP_HIGH[i], 8'hFF, 8'h12);
    end
    rchk(ADDR_IRQ_FLAGS, 8'h0F, 8'h00);
    `CHK(module_irq_o, 4'h0)
    // Edge capture: falling select on module 0 first
    wr(ADDR_MODE_CTRL, 8'h55);
    wr(ADDR_COUNTER_LOW, 8'h77);
    pins(4'hF);
    for (int i = 1; i < NUM_MODULES; i++)
    begin
      rchk(ADDR_CAP_LOW[i], 8'hFF, 8'h77);
    end
    rchk(ADDR_CAP_LOW[0], 8'hFF, 8'h30);
    rchk(ADDR_IRQ_FLAGS, 8'h0F, 8'h0E);
    `CHK(module_irq_o, 4'hE)
    wr(ADDR_COUNTER_LOW, 8'h88);
    pins(4'h0);
    rchk(ADDR_CAP_LOW[0], 8'hFF, 8'h88);
    rchk(ADDR_CAP_LOW[3], 8'hFF, 8'h77);
    wr(ADDR_IRQ_FLAGS, 8'h3F);
    wr(ADDR_IRQ_ENABLES, 8'h00);
    wr(ADDR_MAIN_CTRL, 8'h40);
    wr(ADDR_COUNTER_LOW, 8'h99);
    pins(4'h1);
    rchk(ADDR_CAP_LOW[0], 8'hFF, 8'h99);
    rchk(ADDR_IRQ_FLAGS, 8'h0F, 8'h00);
    // Compare on module 1, reload on overflow from module 0 pair
    wr(ADDR_MODE_CTRL, 8'h08);
    wr(ADDR_CAP_LOW[1], 8'hF0);
    wr(ADDR_CAP_HIGH[1], 8'hFF);
    wr(ADDR_CAP_LOW[0], 8'hD0);
    wr(ADDR_CAP_HIGH[0], 8'hFF);
    wr(ADDR_COUNTER_HIGH, 8'hFF);
    wr(ADDR_IRQ_ENABLES, 8'h10);
    wr(ADDR_MAIN_CTRL, 8'h11);
    wait_for(1, 1'b1, cnt);
    `CHK(module_pin_oe_o, 4'h2)
    rchk(ADDR_IRQ_FLAGS, 8'h02, 8'h02);
    wait_for(1, 1'b0, cnt);
    wait_for(1, 1'b1, cnt);
    `CHK(cnt, 33)
    `CHK(timer_irq_o, 1'b1)
    rchk(ADDR_IRQ_FLAGS, 8'h10, 8'h10);
    wr(ADDR_PORT_DATA, 8'h00);
    wr(ADDR_MAIN_CTRL, 8'h15);
    wait_for(1, 1'b0, cnt);
    wr(ADDR_PORT_DATA, 8'h02);
    wait_for(1, 1'b1, cnt);
    wr(ADDR_IRQ_FLAGS, 8'h3F);
    wait_for(5, 1'b1, cnt);
    `CHK(module_pin_o[1], 1'b1)
    // Clock output: reload FFF6 and divide by two give 20 cycles a half period
    wr(ADDR_MODE_CTRL, 8'h00);
    wr(ADDR_MAIN_CTRL, 8'h00);
    wr(ADDR_CLKOUT_CTRL, 8'h00);
    wr(ADDR_CAP_LOW[0], 8'hF6);
    `CHK(timer_ext_pin_o, 1'b0)
    wr(ADDR_PRESCALER_CTRL, 8'h01);
    wr(ADDR_CLKOUT_CTRL, 8'h04);
    wr(ADDR_MAIN_CTRL, 8'h01);
    wait_for(4, 1'b1, cnt);
    wait_for(4, 1'b0, cnt);
    `CHK(cnt, 20)
    wait_for(4, 1'b1, cnt);
    `CHK(cnt, 20)
    `CHK(timer_ext_pin_oe_o, 1'b1)
    wr(ADDR_CLKOUT_CTRL, 8'h00);
    // External reload, interrupt only with both enables
    wr(ADDR_MAIN_CTRL, 8'h18);
    wr(ADDR_CAP_LOW[0], 8'hCD);
    wr(ADDR_CAP_HIGH[0], 8'hAB);
    `CHK(timer_ext_pin_oe_o, 1'b0)
    for (int k = 0; k < 2; k++)
    begin
      wr(ADDR_IRQ_FLAGS, 8'h3F);
      wr(ADDR_IRQ_ENABLES, k == 0 ? 8'h30 : 8'h20);
      wr(ADDR_COUNTER_LOW, 8'h00);
      @(posedge mclk_i);
      trig_lvl <= 1'b0;
      repeat (10) @(posedge mclk_i);
      trig_lvl <= 1'b1;
      rchk(ADDR_COUNTER_LOW, 8'hFF, 8'hCD);
      rchk(ADDR_COUNTER_HIGH, 8'hFF, 8'hAB);
      `CHK(timer_irq_o, 1'(k == 0))
    end
    // Event counting, one step per falling timer-pin edge
    wr(ADDR_MAIN_CTRL, 8'h02);
    wr(ADDR_COUNTER_LOW, 8'h00);
    @(posedge mclk_i);
    ext_lvl <= 1'b1;
    repeat (10) @(posedge mclk_i);
    ext_lvl <= 1'b0;
    repeat (10) @(posedge mclk_i);
    rchk(ADDR_COUNTER_LOW, 8'hFF, 8'h01);
    results();
  end
endmodule : tccu_top_tb
